// >>> hdl/loop_ctrl_defs.vh
// What this block does
// - Startup sync inhibit bit set suppresses power-up sync pulses to both loops.
// - Interpolation code 0/1/2/3 selects eight, four, two or one phase.
// - Less interpolation ignores more low bits of the 28-bit fraction.
// - Pump current equals 3.125 uA times trim code plus one.
// - Forward step bit moves the VCO phase ahead one eighth, unless backward steps in the same cycle.
// - Only a rising edge of the forward bit gives a step.
// - Backward step bit moves the phase back one eighth, edge triggered.
// - Divider reset bit holds the feedback divider in reset while set.
// - Driver pair reset bit resets drivers three and four while set.
// - Force reset bit starts a cycle ending in sync pulses to both loops.
// - Rational mode: numerator is fraction bits 24:9, denominator the modulus.
// - Modulus is ten register bits above the six lowest fraction bits.
// - Zero modulus means the fraction is a 28-bit fixed-point value.
// - Rational mode with any nonzero order code divides numerator by modulus exactly.
// - Order zero gives no modulation, else floor and ceiling alternate.
`ifndef LOOP_CTRL_DEFS_VH
`define LOOP_CTRL_DEFS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OFS_LOOP_CONTROL   12'h000
`define OFS_FRACTION       12'h004
`define OFS_SHAPER_ORDER   12'h008
`define OFS_STATUS         12'h00C

// ****************************************************************
// Field positions of the loop control and fraction registers
// ****************************************************************
`define BIT_SYNC_INHIBIT   23
`define BIT_INTERP_HI      22
`define BIT_INTERP_LO      21
`define BIT_TRIM_HI        20
`define BIT_TRIM_LO        16
`define BIT_STEP_FWD       15
`define BIT_DIV_RESET      14
`define BIT_PAIR_RESET     13
`define BIT_FORCE_RESET    12
`define BIT_STEP_BWD       11
`define BIT_RATIONAL       10
`define BIT_DENOM_HI       9
`define BIT_DENOM_LO       0
`define BIT_NUMER_HI       24
`define BIT_NUMER_LO       9
`define BIT_FRAC_SHARE_HI  5

// ****************************************************************
// Reset values and timing counts
// ****************************************************************
`define RST_LOOP_CONTROL   24'h00_0000
`define RST_FRACTION       28'h000_0000
`define RST_SHAPER_ORDER   3'h0
`define STARTUP_CYCLES     16'h0040
`define FORCE_CYCLES       16'h0010
`define TRIM_STEP_NA       17'h0_0C35

`endif

// >>> hdl/loop_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "loop_ctrl_defs.vh"

module loop_ctrl #(
    parameter [15:0] STARTUP_LEN = `STARTUP_CYCLES,
    parameter [15:0] FORCE_LEN   = `FORCE_CYCLES
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        clk_en,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg         sync_pulse_first,
    output reg         sync_pulse_second,
    output reg         feedback_div_reset,
    output reg         second_driver_pair_reset,
    output reg         vco_step_forward,
    output reg         vco_step_backward,
    output reg  [2:0]  vco_phase_sel,
    output reg  [4:0]  pump_current_trim,
    output reg  [16:0] pump_current_na,
    output reg  [3:0]  interp_phases,
    output reg  [27:0] frac_effective,
    output reg  [15:0] ratio_denominator,
    output reg  [15:0] ratio_numerator,
    output reg         ratio_active,
    output reg  [2:0]  noise_shaper_order,
    output reg         ceil_select
);

    // ****************************************************************
    // Sequencer states
    // ****************************************************************
    localparam [1:0] ST_STARTUP = 2'd0;
    localparam [1:0] ST_IDLE    = 2'd1;
    localparam [1:0] ST_FORCE   = 2'd2;
    localparam [1:0] ST_SYNC    = 2'd3;

    // ****************************************************************
    // Functions
    // ****************************************************************
    function rise;
        input now_bit;
        input old_bit;
        begin
            rise = now_bit & ~old_bit;
        end
    endfunction

    function [27:0] drop_mask;
        input [1:0] code;
        begin
            case (code)
                2'd0:    drop_mask = 28'hFFF_FFFF;
                2'd1:    drop_mask = 28'hFFF_FFFE;
                2'd2:    drop_mask = 28'hFFF_FFFC;
                default: drop_mask = 28'hFFF_FFF8;
            endcase
        end
    endfunction

    // ****************************************************************
    // Registers
    // ****************************************************************
    reg  [23:0] loop_control_reg;
    reg  [27:0] fraction_reg;
    reg  [2:0]  order_reg;
    reg         fwd_old_reg;
    reg         bwd_old_reg;
    reg         force_old_reg;
    reg         boot_reg;
    reg  [1:0]  state_reg;
    reg  [1:0]  state_next;
    reg  [15:0] count_reg;
    reg  [15:0] count_next;
    reg  [27:0] acc_reg;
    reg  [27:0] acc_next;
    reg         carry_next;

    wire        setup_phase;
    wire        access_done;
    wire        addr_ok;
    wire        do_write;
    wire        step_fwd_ev;
    wire        step_bwd_ev;
    wire        force_ev;
    wire [1:0]  interp_code;
    wire [15:0] denom_full;
    wire [15:0] numer;
    wire        rational_on;
    wire        seq_busy;
    wire [27:0] frac_masked;
    wire [28:0] fixed_sum;
    wire [16:0] ratio_sum;
    wire [16:0] ratio_wrap;
    reg  [31:0] read_word;

    assign setup_phase = psel & ~penable;
    assign access_done = psel & penable & pready;
    assign addr_ok     = (paddr == `OFS_LOOP_CONTROL) | (paddr == `OFS_FRACTION) |
                         (paddr == `OFS_SHAPER_ORDER) | (paddr == `OFS_STATUS);
    assign do_write    = access_done & pwrite & addr_ok;

    assign step_fwd_ev = rise(loop_control_reg[`BIT_STEP_FWD], fwd_old_reg);
    assign step_bwd_ev = rise(loop_control_reg[`BIT_STEP_BWD], bwd_old_reg);
    assign force_ev    = rise(loop_control_reg[`BIT_FORCE_RESET], force_old_reg);

    assign interp_code = loop_control_reg[`BIT_INTERP_HI:`BIT_INTERP_LO];
    // Low six fraction bits double as the bottom of the modulus
    assign denom_full  = {loop_control_reg[`BIT_DENOM_HI:`BIT_DENOM_LO], fraction_reg[`BIT_FRAC_SHARE_HI:0]};
    assign numer       = fraction_reg[`BIT_NUMER_HI:`BIT_NUMER_LO];
    assign rational_on = loop_control_reg[`BIT_RATIONAL] & (denom_full != 16'h0000);
    assign seq_busy    = (state_reg != ST_IDLE);
    assign frac_masked = fraction_reg & drop_mask(interp_code);
    assign fixed_sum   = {1'b0, acc_reg} + {1'b0, frac_masked};
    assign ratio_sum   = {1'b0, acc_reg[15:0]} + {1'b0, numer};
    assign ratio_wrap  = ratio_sum - {1'b0, denom_full};

    // ****************************************************************
    // APB slave
    // ****************************************************************
    always @* begin
        case (paddr)
            `OFS_LOOP_CONTROL: read_word = {8'h00, loop_control_reg};
            `OFS_FRACTION:     read_word = {4'h0, fraction_reg};
            `OFS_SHAPER_ORDER: read_word = {29'h0000_0000, order_reg};
            `OFS_STATUS:       read_word = {24'h00_0000, 1'b0, ceil_select, seq_busy,
                                            ratio_active, 1'b0, vco_phase_sel};
            default:           read_word = 32'h0000_0000;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready           <= 1'b0;
            pslverr          <= 1'b0;
            prdata           <= 32'h0000_0000;
            loop_control_reg <= `RST_LOOP_CONTROL;
            fraction_reg     <= `RST_FRACTION;
            order_reg        <= `RST_SHAPER_ORDER;
        end else if (clk_en) begin
            // No wait state: answer prepared in the setup cycle
            pready  <= setup_phase;
            pslverr <= setup_phase & ~addr_ok;
            if (setup_phase && !pwrite) begin
                prdata <= read_word;
            end else if (access_done) begin
                prdata <= 32'h0000_0000;
            end
            if (do_write) begin
                case (paddr)
                    `OFS_LOOP_CONTROL: loop_control_reg <= pwdata[23:0];
                    `OFS_FRACTION:     fraction_reg     <= pwdata[27:0];
                    `OFS_SHAPER_ORDER: order_reg        <= pwdata[2:0];
                    default:           order_reg        <= order_reg;
                endcase
            end
        end
    end

    // ****************************************************************
    // Startup and force-reset sequencer
    // ****************************************************************
    always @* begin
        state_next = state_reg;
        count_next = count_reg;
        case (state_reg)
            ST_STARTUP: begin
                if (count_reg >= STARTUP_LEN - 16'h0001) begin
                    count_next = 16'h0000;
                    state_next = ST_SYNC;
                end else begin
                    count_next = count_reg + 16'h0001;
                end
            end
            ST_IDLE: begin
                count_next = 16'h0000;
                if (force_ev) begin
                    state_next = ST_FORCE;
                end
            end
            ST_FORCE: begin
                if (count_reg >= FORCE_LEN - 16'h0001) begin
                    count_next = 16'h0000;
                    state_next = ST_SYNC;
                end else begin
                    count_next = count_reg + 16'h0001;
                end
            end
            ST_SYNC: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
                count_next = 16'h0000;
            end
        endcase
    end

    // ****************************************************************
    // Modulator accumulator
    // ****************************************************************
    always @* begin
        acc_next   = acc_reg;
        carry_next = 1'b0;
        if (order_reg == 3'd0) begin
            acc_next = 28'h000_0000;
        end else if (rational_on) begin
            // Exact numerator over modulus, one carry per wrap
            if (ratio_sum >= {1'b0, denom_full}) begin
                acc_next   = {12'h000, ratio_wrap[15:0]};
                carry_next = 1'b1;
            end else begin
                acc_next = {12'h000, ratio_sum[15:0]};
            end
        end else begin
            acc_next   = fixed_sum[27:0];
            carry_next = fixed_sum[28];
        end
    end

    // ****************************************************************
    // State and outputs
    // ****************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg                <= ST_STARTUP;
            count_reg                <= 16'h0000;
            fwd_old_reg              <= 1'b0;
            bwd_old_reg              <= 1'b0;
            force_old_reg            <= 1'b0;
            boot_reg                 <= 1'b1;
            acc_reg                  <= 28'h000_0000;
            sync_pulse_first         <= 1'b0;
            sync_pulse_second        <= 1'b0;
            feedback_div_reset       <= 1'b1;
            second_driver_pair_reset <= 1'b0;
            vco_step_forward         <= 1'b0;
            vco_step_backward        <= 1'b0;
            vco_phase_sel            <= 3'd0;
            pump_current_trim        <= 5'd0;
            pump_current_na          <= `TRIM_STEP_NA;
            interp_phases            <= 4'd8;
            frac_effective           <= 28'h000_0000;
            ratio_denominator        <= 16'h0000;
            ratio_numerator          <= 16'h0000;
            ratio_active             <= 1'b0;
            noise_shaper_order       <= 3'd0;
            ceil_select              <= 1'b0;
        end else if (clk_en) begin
            state_reg     <= state_next;
            count_reg     <= count_next;
            fwd_old_reg   <= loop_control_reg[`BIT_STEP_FWD];
            bwd_old_reg   <= loop_control_reg[`BIT_STEP_BWD];
            force_old_reg <= loop_control_reg[`BIT_FORCE_RESET];
            // Only the first sync cycle after reset is the startup one
            boot_reg      <= boot_reg & (state_reg != ST_SYNC);

            // Startup pulses only when not inhibited; forced ones always
            sync_pulse_first  <= (state_reg == ST_SYNC) &
                                 (~loop_control_reg[`BIT_SYNC_INHIBIT] | ~boot_reg);
            sync_pulse_second <= (state_reg == ST_SYNC) &
                                 (~loop_control_reg[`BIT_SYNC_INHIBIT] | ~boot_reg);

            // Divider held in reset by the bit and during a reset cycle
            feedback_div_reset       <= loop_control_reg[`BIT_DIV_RESET] | seq_busy;
            second_driver_pair_reset <= loop_control_reg[`BIT_PAIR_RESET];

            vco_step_forward  <= step_fwd_ev;
            vco_step_backward <= step_bwd_ev;
            if (step_fwd_ev && !step_bwd_ev) begin
                vco_phase_sel <= vco_phase_sel + 3'd1;
            end else if (step_bwd_ev && !step_fwd_ev) begin
                vco_phase_sel <= vco_phase_sel - 3'd1;
            end

            pump_current_trim <= loop_control_reg[`BIT_TRIM_HI:`BIT_TRIM_LO];
            pump_current_na   <= ({12'h000, loop_control_reg[`BIT_TRIM_HI:`BIT_TRIM_LO]} + 17'h0_0001) *
                                 `TRIM_STEP_NA;
            interp_phases     <= 4'd8 >> interp_code;
            frac_effective    <= frac_masked;
            ratio_denominator <= denom_full;
            ratio_numerator   <= numer;
            ratio_active      <= rational_on;
            noise_shaper_order <= order_reg;

            if (loop_control_reg[`BIT_DIV_RESET] || seq_busy) begin
                acc_reg     <= 28'h000_0000;
                ceil_select <= 1'b0;
            end else begin
                acc_reg     <= acc_next;
                ceil_select <= carry_next;
            end
        end
    end

endmodule // loop_ctrl

`default_nettype wire

// >>> bench/loop_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Port checker for the loop control block
// ****************************************************************
module loop_ctrl_assertions (
    input wire        pclk,
    input wire        presetn,
    input wire        clk_en,
    input wire        psel,
    input wire        penable,
    input wire        pready,
    input wire        pslverr,
    input wire        sync_pulse_first,
    input wire        sync_pulse_second,
    input wire        vco_step_forward,
    input wire        vco_step_backward,
    input wire [4:0]  pump_current_trim,
    input wire [16:0] pump_current_na,
    input wire [3:0]  interp_phases,
    input wire [27:0] frac_effective,
    input wire [15:0] ratio_denominator,
    input wire        ratio_active,
    input wire [2:0]  noise_shaper_order,
    input wire        ceil_select
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_apb_answer: assert property (psel && !penable && clk_en |=> pready ##1 !pready)
        else $error("pready not a single cycle after setup");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_pump_current: assert property (pump_current_na == 17'd3125 * ({12'd0, pump_current_trim} + 17'd1))
        else $error("pump current does not follow trim");
    a_interp_code: assert property (interp_phases inside {4'h8, 4'h4, 4'h2, 4'h1})
        else $error("illegal phase count");
    a_frac_lsb_drop: assert property (interp_phases == 4'h1 |-> frac_effective[2:0] == 3'h0)
        else $error("low fraction bits kept without interpolation");
    a_fwd_one_step: assert property (vco_step_forward |=> !vco_step_forward)
        else $error("forward step repeated");
    a_bwd_one_step: assert property (vco_step_backward |=> !vco_step_backward)
        else $error("backward step repeated");
    a_ratio_zero_mod: assert property (ratio_active |-> ratio_denominator != 16'h0000)
        else $error("ratio active with zero modulus");
    a_order_zero_flat: assert property (noise_shaper_order == 3'h0 && $past(noise_shaper_order) == 3'h0
        |-> !ceil_select)
        else $error("modulation with order zero");
    a_sync_both_loops: assert property (sync_pulse_first == sync_pulse_second)
        else $error("sync pulses not simultaneous");

    c_step: cover property (vco_step_forward);
    c_sync: cover property (sync_pulse_first);
    c_ratio: cover property (ratio_active && ceil_select);
    c_err: cover property (pslverr);
endmodule // loop_ctrl_assertions

bind loop_ctrl loop_ctrl_assertions u_chk (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .sync_pulse_first(sync_pulse_first),
    .sync_pulse_second(sync_pulse_second), .vco_step_forward(vco_step_forward),
    .vco_step_backward(vco_step_backward), .pump_current_trim(pump_current_trim),
    .pump_current_na(pump_current_na), .interp_phases(interp_phases), .frac_effective(frac_effective),
    .ratio_denominator(ratio_denominator), .ratio_active(ratio_active),
    .noise_shaper_order(noise_shaper_order), .ceil_select(ceil_select));
`default_nettype wire

// >>> bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        pclk, presetn, clk_en, psel, penable, pwrite, last_err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic        pready, pslverr, sync_pulse_first, sync_pulse_second, feedback_div_reset;
    logic        second_driver_pair_reset, vco_step_forward, vco_step_backward, ratio_active, ceil_select;
    logic [2:0]  vco_phase_sel, noise_shaper_order, p0;
    logic [4:0]  pump_current_trim;
    logic [16:0] pump_current_na;
    logic [3:0]  interp_phases;
    logic [27:0] frac_effective;
    logic [15:0] ratio_denominator, ratio_numerator;
    int          n_mismatch, comparisons, n_fwd, n_bwd, n_sync, n_ceil, i, c0;

    loop_ctrl #(.STARTUP_LEN(16'h0008), .FORCE_LEN(16'h0002)) dut (.pclk(pclk), .presetn(presetn),
        .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sync_pulse_first(sync_pulse_first),
        .sync_pulse_second(sync_pulse_second), .feedback_div_reset(feedback_div_reset),
        .second_driver_pair_reset(second_driver_pair_reset), .vco_step_forward(vco_step_forward),
        .vco_step_backward(vco_step_backward), .vco_phase_sel(vco_phase_sel),
        .pump_current_trim(pump_current_trim), .pump_current_na(pump_current_na),
        .interp_phases(interp_phases), .frac_effective(frac_effective), .ratio_denominator(ratio_denominator),
        .ratio_numerator(ratio_numerator), .ratio_active(ratio_active), .noise_shaper_order(noise_shaper_order),
        .ceil_select(ceil_select));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // Event counters for pulse outputs, sampled mid-cycle away from the launching edge
    always @(negedge pclk) begin
        if (vco_step_forward === 1'b1) n_fwd++;
        if (vco_step_backward === 1'b1) n_bwd++;
        if (sync_pulse_first === 1'b1) n_sync++;
        if (ceil_select === 1'b1) n_ceil++;
    end

    task automatic results;
        if (n_mismatch == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
        int k;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 20) begin
            n_mismatch++;
            results();
        end
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        logic [31:0] x;
        apb(1'b1, a, v, x);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] x;
        apb(1'b0, a, 32'h0000_0000, x);
        chk(x, exp);
    endtask

    task automatic wait_sync(input int s0);
        for (i = 0; i < 200 && n_sync == s0; i++) @(posedge pclk);
        chk(n_sync, s0 + 1);
        if (n_sync == s0) results();
    endtask

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        clk_en = 1'b1;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        wait_sync(0);
        repeat (2) @(posedge pclk);
        chk(feedback_div_reset, 1'b0);
        rd_chk(12'h000, 32'h0000_0000);
        wr(12'h004, 32'hFFFF_FFFF);
        rd_chk(12'h004, 32'h0FFF_FFFF);
        wr(12'h008, 32'h0000_000F);
        rd_chk(12'h008, 32'h0000_0007);
        wr(12'h008, 32'h0000_0000);
        apb(1'b0, 12'h010, 32'h0000_0000, d);
        chk(d, 32'h0000_0000);
        chk(last_err, 1'b1);
        for (int c = 0; c < 32; c++) begin
            wr(12'h000, 32'(c) << 16);
            chk(pump_current_na, 3125 * (c + 1));
            chk(pump_current_trim, c);
        end
        for (int s = 0; s < 4; s++) begin
            wr(12'h000, 32'(s) << 21);
            chk(interp_phases, 8 >> s);
            chk(frac_effective, 28'hFFF_FFFF & ~((28'h1 << s) - 1));
        end
        apb(1'b0, 12'h00C, 32'h0000_0000, d);
        p0 = d[2:0];
        chk(last_err, 1'b0);
        wr(12'h000, 32'h0000_8000);
        wr(12'h000, 32'h0000_8000);
        chk(n_fwd, 1);
        wr(12'h000, 32'h0000_0000);
        wr(12'h000, 32'h0000_8000);
        rd_chk(12'h00C, {29'h0, p0 + 3'd2});
        wr(12'h000, 32'h0000_0800);
        wr(12'h000, 32'h0000_0800);
        chk(n_bwd, 1);
        rd_chk(12'h00C, {29'h0, p0 + 3'd1});
        wr(12'h000, 32'h0000_4000);
        chk(feedback_div_reset, 1'b1);
        wr(12'h000, 32'h0000_2000);
        chk(feedback_div_reset, 1'b0);
        chk(second_driver_pair_reset, 1'b1);
        wr(12'h000, 32'h0000_0000);
        chk(second_driver_pair_reset, 1'b0);
        wr(12'h000, 32'h0080_1000);
        wait_sync(1);
        wr(12'h004, 32'h0000_0203);
        wr(12'h000, 32'h0000_0401);
        chk(ratio_denominator, 16'h0043);
        chk(ratio_numerator, 16'h0001);
        chk(ratio_active, 1'b1);
        wr(12'h004, 32'h0000_0200);
        wr(12'h000, 32'h0000_0400);
        chk(ratio_active, 1'b0);
        wr(12'h004, 32'h0000_0202);
        wr(12'h000, 32'h0060_0400);
        wr(12'h008, 32'h0000_0001);
        chk(noise_shaper_order, 3'd1);
        wr(12'h000, 32'h0060_4400);
        wr(12'h000, 32'h0060_0400);
        c0 = n_ceil;
        repeat (20) @(posedge pclk);
        chk(n_ceil - c0, 10);
        wr(12'h008, 32'h0000_0000);
        c0 = n_ceil;
        repeat (20) @(posedge pclk);
        chk(n_ceil - c0, 0);
        // Second reset: inhibit written before the startup sync falls due
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        c0 = n_sync;
        wr(12'h000, 32'h0080_0000);
        repeat (20) @(posedge pclk);
        chk(n_sync, c0);
        chk(feedback_div_reset, 1'b0);
        results();
    end
endmodule // tb
`default_nettype wire
